// ---- aorc_top.sv ----
// conversion control with oversampling and read during conversion
`timescale 1ns/1ps
`default_nettype none
module aorc_top
  import aorc_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // device pins
  input wire logic convert_start_first,
  input wire logic convert_start_second,
  input wire logic [2:0] oversample_ratio_sel,
  input wire logic interface_select,
  input wire logic byte_or_serial_select,
  input wire logic cs_n,
  output logic busy,
  // converter core
  output logic adc_sample_req,
  input wire logic adc_sample_valid,
  input wire aorc_res_t adc_sample_data,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  aorc_state_s q;
  aorc_state_s d;
  aorc_pins_s pins_raw;
  aorc_pins_s pins;
  aorc_res_t mean;
  logic [2:0] shift;
  logic [AORC_CNTW-1:0] nsamp;
  logic [AORC_CNTW-1:0] cnt_nx;
  logic acc_clr;
  logic acc_add;
  logic wr_go;
  logic sw_go;
  logic both;
  logic start;
  logic [31:0] rd_word;
  logic [5:0] res_off;

  // pins cross into the clock domain before any logic looks at them
  assign pins_raw = '{
    cs_n: cs_n,
    byte_sel: byte_or_serial_select,
    if_sel: interface_select,
    os: oversample_ratio_sel,
    cb: convert_start_second,
    ca: convert_start_first
  };

  aorc_sync #(
    .W($bits(aorc_pins_s))
  ) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .din(pins_raw),
    .dout(pins)
  );

  // ratio code 7 means a single sample per result
  assign shift = (q.ratio == AORC_RATIO_NONE) ? 3'h0 : q.ratio;
  assign nsamp = {{(AORC_CNTW-1){1'b0}}, 1'b1} << shift;
  assign cnt_nx = q.cnt + {{(AORC_CNTW-1){1'b0}}, 1'b1};

  // one filter channel per input
  for (genvar i = 0; i < AORC_NCH; i++) begin : g_avg
    aorc_avg #(
      .DW(AORC_DW),
      .AW(AORC_DW + AORC_HEAD)
    ) u_avg (
      .clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .clr(acc_clr),
      .add(acc_add),
      .shift(shift),
      .sample(adc_sample_data[i]),
      .mean(mean[i])
    );
  end

  // bus write strobes, taken on the cycle waitrequest is low
  assign wr_go = avs_write && !q.wreq;
  assign sw_go = wr_go && (avs_address == AORC_ADDR_CTRL) &&
                 avs_byteenable[0] && avs_writedata[AORC_CTRL_SW_START];
  // the pins start only when both are high, so a skewed pair starts once
  assign both = pins.ca & pins.cb;
  assign start = !q.busy && ((both && !q.both_prev && q.pin_en) || sw_go);

  // read decode; results are never blocked by busy
  assign res_off = avs_address - AORC_ADDR_RES0;
  always_comb begin
    rd_word = '0;
    if (avs_address == AORC_ADDR_CTRL) begin
      rd_word[AORC_CTRL_PIN_EN] = q.pin_en;
    end else if (avs_address == AORC_ADDR_STAT) begin
      rd_word[AORC_STAT_BUSY] = q.busy;
      rd_word[AORC_STAT_RATIO +: 3] = q.ratio;
      rd_word[AORC_STAT_IF +: 2] = q.iface;
      rd_word[AORC_STAT_OVL] = q.overlap;
    end else if (avs_address >= AORC_ADDR_RES0 &&
                 res_off < AORC_RES_SPAN) begin
      rd_word[AORC_DW-1:0] = q.res[res_off[5:2]];
    end
  end

  // next-state logic for the whole block
  always_comb begin
    d = q;
    d.req = 1'b0;
    d.wreq = 1'b1;
    acc_clr = 1'b0;
    acc_add = 1'b0;
    d.both_prev = both;
    // busy length counter saturates, so a very long conversion never wraps
    if (!q.busy) begin
      d.blen = '0;
    end else if (q.blen != '1) begin
      d.blen = q.blen + AORC_BLENW'(1);
    end

    // interface mode from the two select pins
    if (!pins.if_sel) begin
      d.iface = AORC_IF_PAR;
    end else if (pins.byte_sel) begin
      d.iface = AORC_IF_BYTE;
    end else begin
      d.iface = AORC_IF_SER;
    end

    // bus slave: one wait cycle, then the answer
    if ((avs_read || avs_write) && q.wreq) begin
      d.wreq = 1'b0;
    end
    if (avs_read && q.wreq) begin
      d.rdata = rd_word;
    end
    if (wr_go && avs_byteenable[0]) begin
      if (avs_address == AORC_ADDR_CTRL) begin
        d.pin_en = avs_writedata[AORC_CTRL_PIN_EN];
      end else if (avs_address == AORC_ADDR_STAT &&
                   avs_writedata[AORC_STAT_OVL]) begin
        d.overlap = 1'b0;
      end
    end

    // conversion sequence; a start while busy is ignored
    case (q.st)
      AORC_ST_IDLE: begin
        if (start) begin
          d.busy = 1'b1;
          d.cnt = '0;
          acc_clr = 1'b1;
          d.st = AORC_ST_REQ;
        end
      end
      AORC_ST_REQ: begin
        d.req = 1'b1;
        d.st = AORC_ST_WAIT;
      end
      AORC_ST_WAIT: begin
        if (adc_sample_valid) begin
          acc_add = 1'b1;
          d.cnt = cnt_nx;
          // more samples per result means a longer busy
          if (cnt_nx == nsamp) begin
            d.st = AORC_ST_UPD;
          end else begin
            d.st = AORC_ST_REQ;
          end
        end
      end
      AORC_ST_UPD: begin
        d.res = mean;
        // a read still framed here may see a torn update; flag it
        if (!pins.cs_n) begin
          d.overlap = 1'b1;
        end
        d.st = AORC_ST_END;
      end
      AORC_ST_END: begin
        d.busy = 1'b0;
        d.ratio = pins.os;
        d.st = AORC_ST_IDLE;
      end
      default: begin
        d.st = AORC_ST_IDLE;
      end
    endcase
  end

  // the single state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= AORC_STATE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign busy = q.busy;
  assign adc_sample_req = q.req;
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wreq;

  // checks; a frozen clock enable simply disables them
  a_busy_on_start: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    (q.st == AORC_ST_IDLE && start) |=> q.busy && q.st == AORC_ST_REQ
  ) else $error("busy did not rise on start");

  a_update_then_fall: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    (q.st == AORC_ST_UPD) |=> q.busy ##1 !q.busy
  ) else $error("busy did not fall right after update");

  a_ratio_at_fall: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    $fell(q.busy) |-> q.ratio == $past(pins.os)
  ) else $error("ratio not latched at busy fall");

  a_results_hold: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    (q.st != AORC_ST_UPD) |=> $stable(q.res)
  ) else $error("results changed outside update");

  a_read_answered: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    (avs_read && q.wreq) |=> !avs_waitrequest &&
      avs_readdata == $past(rd_word)
  ) else $error("read not answered in one wait cycle");

  a_busy_length: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    $fell(q.busy) |->
      q.blen >= (AORC_BLENW'({$past(nsamp), 1'b0}) + 9'h002)
  ) else $error("busy too short for ratio");

  a_avg_loaded: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    (q.st == AORC_ST_UPD) |=> q.res == $past(mean)
  ) else $error("results not taken from the filter");

  a_iface_decode: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    pins.if_sel |=>
      q.iface == ($past(pins.byte_sel) ? AORC_IF_BYTE : AORC_IF_SER)
  ) else $error("interface mode decoded wrongly");

  a_iface_parallel: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    !pins.if_sel |=> q.iface == AORC_IF_PAR
  ) else $error("parallel mode not selected");

  a_req_single_pulse: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    adc_sample_req |=> !adc_sample_req
  ) else $error("sample request longer than one cycle");

  a_busy_rise_cause: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    $rose(q.busy) |-> $past(start)
  ) else $error("busy rose without a start");

  a_overlap_flagged: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    (q.st == AORC_ST_UPD && !pins.cs_n) |=> q.overlap
  ) else $error("overlap not flagged during update");

  a_ratio_held: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    (q.st != AORC_ST_END) |=> $stable(q.ratio)
  ) else $error("ratio changed outside busy fall");

  a_wait_at_rest: assert property (@(posedge ref_clk)
    disable iff (rst || !ce)
    !(avs_read || avs_write) |=> avs_waitrequest
  ) else $error("waitrequest low without a request");

endmodule
`default_nettype wire

// ---- aorc_pkg.sv ----
// shared constants and types of the oversampling read control block
package aorc_pkg;

  // channel count and result width
  localparam int AORC_NCH = 6;
  localparam int AORC_DW = 16;
  // accumulator headroom for up to 64 summed samples
  localparam int AORC_HEAD = 6;
  localparam int AORC_CNTW = 7;
  localparam int AORC_BLENW = 9;

  // register byte addresses
  localparam logic [5:0] AORC_ADDR_CTRL = 6'h00;
  localparam logic [5:0] AORC_ADDR_STAT = 6'h04;
  localparam logic [5:0] AORC_ADDR_RES0 = 6'h10;
  localparam logic [5:0] AORC_RES_SPAN = 6'h18;

  // control register bits
  localparam int AORC_CTRL_SW_START = 0;
  localparam int AORC_CTRL_PIN_EN = 1;
  // status register fields
  localparam int AORC_STAT_BUSY = 0;
  localparam int AORC_STAT_RATIO = 1;
  localparam int AORC_STAT_IF = 4;
  localparam int AORC_STAT_OVL = 6;

  // ratio code that selects no averaging
  localparam logic [2:0] AORC_RATIO_NONE = 3'h7;

  typedef enum logic [1:0] {
    AORC_IF_PAR,
    AORC_IF_BYTE,
    AORC_IF_SER
  } aorc_iface_e;

  typedef enum logic [2:0] {
    AORC_ST_IDLE,
    AORC_ST_REQ,
    AORC_ST_WAIT,
    AORC_ST_UPD,
    AORC_ST_END
  } aorc_state_e;

  typedef logic [AORC_NCH-1:0][AORC_DW-1:0] aorc_res_t;

  // pins after the synchroniser
  typedef struct packed {
    logic cs_n;
    logic byte_sel;
    logic if_sel;
    logic [2:0] os;
    logic cb;
    logic ca;
  } aorc_pins_s;

  // whole state of the top module
  typedef struct packed {
    aorc_state_e st;
    logic busy;
    logic req;
    logic [2:0] ratio;
    logic [AORC_CNTW-1:0] cnt;
    logic both_prev;
    logic pin_en;
    logic overlap;
    aorc_iface_e iface;
    aorc_res_t res;
    logic wreq;
    logic [31:0] rdata;
    logic [AORC_BLENW-1:0] blen;
  } aorc_state_s;

  localparam aorc_state_s AORC_STATE_RST = '{
    st: AORC_ST_IDLE,
    iface: AORC_IF_PAR,
    wreq: 1'b1,
    pin_en: 1'b1,
    default: '0
  };

endpackage

// ---- aorc_sync.sv ----
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module aorc_sync
  import aorc_pkg::*;
#(
  parameter int W = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // pins in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } aorc_sync_s;

  aorc_sync_s q;
  aorc_sync_s d;

  // first stage feeds only the second stage
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule
`default_nettype wire

// ---- aorc_avg.sv ----
// one channel of the averaging filter: accumulate, then shift down
`timescale 1ns/1ps
`default_nettype none
module aorc_avg
  import aorc_pkg::*;
#(
  parameter int DW = AORC_DW,
  parameter int AW = AORC_DW + AORC_HEAD
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic clr,
  input wire logic add,
  input wire logic [2:0] shift,
  // data
  input wire logic [DW-1:0] sample,
  output logic [DW-1:0] mean
);

  typedef struct packed {
    logic signed [AW-1:0] acc;
  } aorc_avg_s;

  aorc_avg_s q;
  aorc_avg_s d;
  logic signed [AW-1:0] shifted;

  // samples are two's complement, so extend the sign before adding
  always_comb begin
    d = q;
    if (clr) begin
      d.acc = '0;
    end else if (add) begin
      d.acc = q.acc + {{(AW-DW){sample[DW-1]}}, sample};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // power-of-two count, so the divide is an arithmetic shift
  assign shifted = q.acc >>> shift;
  assign mean = shifted[DW-1:0];

endmodule
`default_nettype wire

// ---- aorc_core_model.sv ----
// converter core model: answers each sample request after a set latency
`timescale 1ns/1ps
`default_nettype none
module aorc_core_model
  import aorc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // sample handshake with the block
  input wire logic adc_sample_req,
  output logic adc_sample_valid,
  output aorc_res_t adc_sample_data,
  // set by the bench
  input wire logic [3:0] lat,
  input wire logic [15:0] base
);
  logic [3:0] wait_q;
  logic pend_q;
  logic odd_q;

  // odd samples sit 0x100 above even ones, so a mean differs from a sample
  always @(posedge ref_clk) begin
    adc_sample_valid <= 1'b0;
    if (rst) begin
      pend_q <= 1'b0;
      odd_q <= 1'b0;
      wait_q <= '0;
      adc_sample_data <= '0;
    end else if (adc_sample_req) begin
      pend_q <= 1'b1;
      wait_q <= lat;
    end else if (pend_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      odd_q <= ~odd_q;
      adc_sample_valid <= 1'b1;
      for (int i = 0; i < AORC_NCH; i++) begin
        adc_sample_data[i] <= base + 16'(i * 17) + (odd_q ? 16'h0100 : 16'h0000);
      end
    end else begin
      // no stale value while idle: the data toggles on every cycle with no request pending
      adc_sample_data <= ~adc_sample_data;
    end
  end
endmodule
`default_nettype wire

// ---- tb_adc_oversample_read_control.sv ----
// self-checking bench of the oversampling read control block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_oversample_read_control;
  import aorc_pkg::*;
  typedef struct packed {
    logic [2:0] code; logic ifs; logic bys; logic [1:0] exp_if;
  } aorc_row_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] be = 4'hF;
  logic ca = 1'b0;
  logic cb = 1'b0;
  logic [2:0] os = 3'h0;
  logic ifs = 1'b0;
  logic bys = 1'b0;
  logic cs_n = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdv, avs_rdata, mid, prev0;
  logic busy, req, vld, wreq;
  aorc_res_t sdata;
  logic [3:0] lat = 4'h9;
  logic [15:0] base = 16'h0000;
  logic [15:0] e;
  logic [2:0] cur = 3'h0;
  int fail_count = 0;
  int n_checks = 0;
  int bsum = 0;
  int n, pn, len, plen, par;
  aorc_row_s rows [9];

  aorc_top dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .convert_start_first(ca), .convert_start_second(cb),
    .oversample_ratio_sel(os), .interface_select(ifs),
    .byte_or_serial_select(bys), .cs_n(cs_n), .busy(busy),
    .adc_sample_req(req), .adc_sample_valid(vld), .adc_sample_data(sdata),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(avs_rdata),
    .avs_waitrequest(wreq));
  aorc_core_model core_u (.ref_clk(ref_clk), .rst(rst),
    .adc_sample_req(req), .adc_sample_valid(vld), .adc_sample_data(sdata),
    .lat(lat), .base(base));

  always #25 ref_clk = ~ref_clk;
  // running count of busy cycles; a conversion's length is a difference
  always @(posedge ref_clk) if (busy === 1'b1) bsum <= bsum + 1;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (wreq === 1'b0) break;
    end
    rdv = avs_rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 50) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic wait_busy(input logic lvl);
    int k;
    for (k = 0; k < 3000 && busy !== lvl; k++) @(posedge ref_clk);
    if (k == 3000) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  // one conversion, with a result read while busy is high
  task automatic conv(input logic sw, output logic [31:0] m, output int l);
    int s;
    s = bsum;
    if (sw) bus(1'b1, AORC_ADDR_CTRL, 32'h3);
    else begin
      ca <= 1'b1;
      cb <= 1'b1;
    end
    wait_busy(1'b1);
    bus(1'b0, AORC_ADDR_RES0, 32'h0);
    m = rdv;
    wait_busy(1'b0);
    ca <= 1'b0;
    cb <= 1'b0;
    repeat (4) @(posedge ref_clk);
    l = bsum - s;
  endtask

  initial begin
    rows = '{'{3'h7,1'b0,1'b0,2'h0}, '{3'h0,1'b1,1'b1,2'h1},
      '{3'h1,1'b1,1'b0,2'h2}, '{3'h2,1'b0,1'b1,2'h0},
      '{3'h3,1'b1,1'b1,2'h1}, '{3'h4,1'b1,1'b0,2'h2},
      '{3'h5,1'b0,1'b0,2'h0}, '{3'h6,1'b1,1'b1,2'h1},
      '{3'h7,1'b1,1'b0,2'h2}};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    // values after reset, and an unmapped place
    chk(busy, 1'b0);
    bus(1'b0, AORC_ADDR_STAT, 32'h0);
    chk(rdv, 32'h0);
    bus(1'b0, AORC_ADDR_CTRL, 32'h0);
    chk(rdv, 32'h2);
    bus(1'b0, 6'h3C, 32'h0);
    chk(rdv, 32'h0);
    $display("test reset done");
    prev0 = 32'h0;
    pn = 0;
    plen = 0;
    par = 0;
    for (int r = 0; r < 9; r++) begin
      os <= rows[r].code;
      ifs <= rows[r].ifs;
      bys <= rows[r].bys;
      base <= 16'h0800 * 16'(r + 1);
      repeat (4) @(posedge ref_clk);
      conv(r[0], mid, len);
      chk(mid, prev0);
      n = (cur == 3'h7) ? 1 : (1 << cur);
      chk(len >= 2 * n + 2, 1'b1);
      if (n > pn) chk(len > plen, 1'b1);
      bus(1'b0, AORC_ADDR_STAT, 32'h0);
      chk(rdv, {26'h0, rows[r].exp_if, rows[r].code, 1'b0});
      for (int c = 0; c < AORC_NCH; c++) begin
        e = 16'h0800 * 16'(r + 1) + 16'(c * 17);
        e = e + ((n > 1) ? 16'h0080 : (par[0] ? 16'h0100 : 16'h0000));
        bus(1'b0, AORC_ADDR_RES0 + 6'(4 * c), 32'h0);
        chk(rdv, {16'h0, e});
        if (c == 0) prev0 = {16'h0, e};
      end
      par = par ^ (n & 1);
      pn = n;
      plen = len;
      cur = rows[r].code;
      $display("test row %0d done", r);
    end
    // select low over the update with a prompt core: sticky flag, then clear
    lat <= 4'h0;
    cs_n <= 1'b0;
    conv(1'b1, mid, len);
    cs_n <= 1'b1;
    bus(1'b0, AORC_ADDR_STAT, 32'h0);
    chk(rdv[6], 1'b1);
    bus(1'b1, AORC_ADDR_STAT, 32'h40);
    bus(1'b0, AORC_ADDR_STAT, 32'h0);
    chk(rdv[6], 1'b0);
    $display("test overlap done");
    // pin start disabled: raising both start pins must not start
    bus(1'b1, AORC_ADDR_CTRL, 32'h0);
    ca <= 1'b1;
    cb <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(busy, 1'b0);
    ca <= 1'b0;
    cb <= 1'b0;
    bus(1'b1, AORC_ADDR_CTRL, 32'h2);
    $display("test pin enable done");
    // a write without byte 0 enabled must leave pin start enabled
    be <= 4'hE;
    bus(1'b1, AORC_ADDR_CTRL, 32'h0);
    be <= 4'hF;
    bus(1'b0, AORC_ADDR_CTRL, 32'h0);
    chk(rdv, 32'h2);
    $display("test byte enable done");
    // clock enable low freezes even the pin synchronisers: no start
    ce <= 1'b0;
    ca <= 1'b1;
    cb <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(busy, 1'b0);
    ce <= 1'b1;
    wait_busy(1'b1);
    chk(busy, 1'b1);
    wait_busy(1'b0);
    ca <= 1'b0;
    cb <= 1'b0;
    $display("test clock enable done");
    // mid-run reset with pin start off: pin enable, busy, ratio and the first result back to reset values
    bus(1'b1, AORC_ADDR_CTRL, 32'h0);
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    chk(busy, 1'b0);
    bus(1'b0, AORC_ADDR_CTRL, 32'h0);
    chk(rdv, 32'h2);
    bus(1'b0, AORC_ADDR_STAT, 32'h0);
    chk(rdv, 32'h20);
    bus(1'b0, AORC_ADDR_RES0, 32'h0);
    chk(rdv, 32'h0);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
